/* File: shared/isp_boot_map.vh */
/*
  constants for the in-system programming and boot-source control block:
  register addresses, field positions, unlock keys and reset values.
  assumes a byte-wide register behind a 32-bit classic wishbone slave.
*/
`ifndef ISP_BOOT_MAP_VH
`define ISP_BOOT_MAP_VH

// register byte addresses (printed offsets 0xBF is not a multiple of four)
`define IDX_BOOT_CONTROL 8'hBF
`define IDX_WRITE_UNLOCK 8'hC0
`define IDX_ISP_STATUS 8'hC1
`define ADDR_BOOT_CONTROL 10'h2FC
`define ADDR_WRITE_UNLOCK 10'h300
`define ADDR_ISP_STATUS 10'h304

// control register fields
`define BIT_REBOOT 7
`define BIT_EXTRA_RAM 4
`define BIT_LOADER_SEL 1
`define BIT_PROG_EN 0

// unlock sequence keys
`define UNLOCK_KEY_FIRST 8'h87
`define UNLOCK_KEY_SECOND 8'h59

// reset values
`define CONTROL_RESET 8'h00
`define PC_RESET 16'h0000

// reboot counter load value; systemReset stays high one cycle longer than this
`define REBOOT_PULSE_CYCLES 4'h4

`endif

/* File: core/boot_strap_sync.v */
/*
  two-stage synchroniser for the boot strap pins.
  assumes pins are asynchronous to mclk.
*/
`timescale 1ns/1ps
module boot_strap_sync #(
  parameter WIDTH = 3
) (
  input wire mclk,
  input wire nrst,
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] pinSync
);
  reg [WIDTH-1:0] stageOne; // first stage, read only by second

  // two flip-flops; reset to high (inactive straps)
  always @(posedge mclk) begin
    if (!nrst) begin
      stageOne <= {WIDTH{1'b1}};
      pinSync <= {WIDTH{1'b1}};
    end else begin
      stageOne <= pinIn;
      pinSync <= stageOne;
    end
  end
endmodule // boot_strap_sync

/* File: core/write_unlock_fsm.v */
/*
  unlock sequencer: control register becomes writable after two keys.
  assumes keyWrite is a one-cycle pulse with keyData valid.
*/
`timescale 1ns/1ps
`include "isp_boot_map.vh"
module write_unlock_fsm (
  input wire mclk,
  input wire nrst,
  input wire keyWrite,
  input wire [7:0] keyData,
  output reg writeOpen
);
  localparam LOCKED = 3'b001;
  localparam HALF = 3'b010;
  localparam OPEN = 3'b100;
  reg [2:0] state; // one-hot state
  reg [2:0] next_state; // next state

  // decide next state from each unlock write
  always @* begin
    next_state = state;
    if (keyWrite) begin
      case (state)
        LOCKED: next_state = (keyData == `UNLOCK_KEY_FIRST) ? HALF : LOCKED;
        HALF: next_state = (keyData == `UNLOCK_KEY_SECOND) ? OPEN : LOCKED;
        // any unlock write while open closes access again; control register writes do not
        OPEN: next_state = LOCKED;
        default: next_state = LOCKED;
      endcase
    end
  end

  // state register and registered output
  always @(posedge mclk) begin
    if (!nrst) begin
      state <= LOCKED;
      writeOpen <= 1'b0;
    end else begin
      state <= next_state;
      writeOpen <= (next_state == OPEN);
    end
  end
endmodule // write_unlock_fsm

/* File: core/isp_boot_mode_control.v */
/*
  in-system programming and boot-source control: control register,
  unlock sequence, strap sampling, isp entry via idle/wake, soft reboot.
  assumes a 32-bit classic wishbone master, cpu idle/wake status inputs,
  and that the cpu consumes pcClear and systemReset pulses.
*/
`timescale 1ns/1ps
`include "isp_boot_map.vh"

// Overview of operation
// - reboot when reboot, select, enable all set
// - top bit reads one in forced boot
// - extra ram enable bit switches aux ram
// - select zero: loader in app rom, loader rom target
// - select one: loader in loader rom, app target
// - enable enters isp after idle then wake
// - flash operations only during idle period
// - enable zero keeps flash read only
// - plain power-on fetches from application rom
// - forced condition at power-up boots loader rom
// - unlock keys 87H then 59H, else relock
// - forced boot when single low or both low
// - clear program counter switching to loader rom
module isp_boot_mode_control (
  input wire mclk,
  input wire nrst,
  input wire porEvent,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire cpuIdle,
  input wire cpuWake,
  input wire bootStrapLow,
  input wire bootStrapHigh,
  input wire bootStrapSingle,
  output reg systemReset,
  output reg pcClear,
  output reg fetchFromLoader,
  output reg extraRamOn,
  output reg reprogramLoaderRom,
  output reg ispActive,
  output reg flashOpAllowed
);
  wire [2:0] strapSync; // synchronised straps: single, high, low
  wire writeOpen; // control register writable
  reg [7:0] control; // stored control bits (7 never stored)
  reg forcedBoot; // forced loader boot status, survives soft reboot
  reg [1:0] strapWait; // edges left until synced straps are sampled
  reg armed; // enable set and idle entered
  reg [3:0] rebootCount; // reboot pulse stretch
  reg reqActive; // wishbone request present
  reg [9:0] byteAddr; // low address bits
  reg ctrlWrite; // control write strobe
  reg keyWrite; // unlock write strobe
  reg [7:0] next_control; // next control value
  reg [31:0] next_rdata; // read mux
  reg rebootReq; // reboot condition on this write

  boot_strap_sync #(
    .WIDTH(3)
  ) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pinIn({bootStrapSingle, bootStrapHigh, bootStrapLow}),
    .pinSync(strapSync)
  );

  write_unlock_fsm u_unlock (
    .mclk(mclk),
    .nrst(nrst),
    .keyWrite(keyWrite),
    .keyData(wb_dat_i[7:0]),
    .writeOpen(writeOpen)
  );

  // bus decode; byte lane 0 carries the 8-bit data
  always @* begin
    reqActive = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    byteAddr = wb_adr_i[9:0];
    ctrlWrite = reqActive & wb_we_i & wb_sel_i[0] &
      (byteAddr == `ADDR_BOOT_CONTROL) & writeOpen;
    keyWrite = reqActive & wb_we_i & wb_sel_i[0] &
      (byteAddr == `ADDR_WRITE_UNLOCK);
  end

  // next control value; reserved and must-be-zero bits forced low
  always @* begin
    next_control = control;
    rebootReq = 1'b0;
    if (ctrlWrite) begin
      next_control = {1'b0, 2'b00, wb_dat_i[`BIT_EXTRA_RAM], 2'b00,
        wb_dat_i[`BIT_LOADER_SEL], wb_dat_i[`BIT_PROG_EN]};
      rebootReq = wb_dat_i[`BIT_REBOOT] & wb_dat_i[`BIT_LOADER_SEL] &
        wb_dat_i[`BIT_PROG_EN];
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    next_rdata = 32'h00000000;
    case (byteAddr)
      `ADDR_BOOT_CONTROL:
        next_rdata = {24'h000000, forcedBoot, control[6:0]};
      `ADDR_ISP_STATUS:
        next_rdata = {29'h00000000, armed, ispActive, writeOpen};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // wishbone answer one cycle after the request, dropped next cycle
  always @(posedge mclk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= reqActive;
      wb_dat_o <= reqActive ? next_rdata : 32'h00000000;
    end
  end

  // control register; soft reboot also clears it
  always @(posedge mclk) begin
    if (!nrst) begin
      control <= `CONTROL_RESET;
    end else if (rebootCount != 4'h0) begin
      control <= `CONTROL_RESET;
    end else begin
      control <= next_control;
    end
  end

  // forced-boot status: sampled once after power-on, kept over reboot;
  // the sample waits until the synchroniser holds real pin values, since
  // its reset image (all high) would otherwise hide a held strap
  always @(posedge mclk) begin
    if (!nrst) begin
      forcedBoot <= 1'b0;
      strapWait <= 2'h3;
    end else if (porEvent) begin
      strapWait <= 2'h3;
    end else if (strapWait == 2'h1) begin
      strapWait <= 2'h0;
      forcedBoot <= ~strapSync[2] | (~strapSync[1] & ~strapSync[0]);
    end else if (strapWait != 2'h0) begin
      strapWait <= strapWait - 2'h1; // synchroniser still filling
    end
  end

  // reboot pulse stretch
  always @(posedge mclk) begin
    if (!nrst) begin
      rebootCount <= 4'h0;
    end else if (rebootReq) begin
      rebootCount <= `REBOOT_PULSE_CYCLES;
    end else if (rebootCount != 4'h0) begin
      rebootCount <= rebootCount - 4'h1;
    end
  end

  // isp entry: enable, then idle, then wake
  always @(posedge mclk) begin
    if (!nrst || rebootCount != 4'h0) begin
      armed <= 1'b0;
      ispActive <= 1'b0;
      pcClear <= 1'b0;
    end else if (!control[`BIT_PROG_EN]) begin
      armed <= 1'b0;
      ispActive <= 1'b0;
      pcClear <= 1'b0;
    end else begin
      pcClear <= 1'b0;
      if (cpuIdle && !ispActive) begin
        armed <= 1'b1;
      end
      if (armed && cpuWake && !ispActive) begin
        ispActive <= 1'b1;
        armed <= 1'b0;
        // entering isp with select one (loader rom) clears the program counter
        pcClear <= ~control[`BIT_LOADER_SEL] ? 1'b0 : 1'b1;
      end
    end
  end

  // derived outputs, all registered
  always @(posedge mclk) begin
    if (!nrst) begin
      systemReset <= 1'b0;
      fetchFromLoader <= 1'b0;
      extraRamOn <= 1'b0;
      reprogramLoaderRom <= 1'b0;
      flashOpAllowed <= 1'b0;
    end else begin
      systemReset <= (rebootCount != 4'h0) | rebootReq;
      // loader rom on forced boot or in isp with select one, else application rom
      fetchFromLoader <= forcedBoot |
        (ispActive & control[`BIT_LOADER_SEL]);
      extraRamOn <= control[`BIT_EXTRA_RAM];
      reprogramLoaderRom <= ~control[`BIT_LOADER_SEL];
      flashOpAllowed <= ispActive & cpuIdle &
        control[`BIT_PROG_EN];
    end
  end
endmodule // isp_boot_mode_control

/* File: bench/boot_board.sv */
/* board strap model for the boot-control block
   assumes the bench picks a strap code and holds it through reset */
`timescale 1ns/1ps
module boot_board (
  input wire [1:0] mode,
  output logic bootStrapLow,
  output logic bootStrapHigh,
  output logic bootStrapSingle
);
  // pins sit pulled high; code 1 pulls both port-2 straps, 2 the single
  assign bootStrapLow = !(mode == 2'h1);
  assign bootStrapHigh = !(mode == 2'h1);
  assign bootStrapSingle = !(mode == 2'h2);
endmodule // boot_board

/* File: bench/isp_boot_checker.sv */
/* port assertions for the boot-control block
   assumes it is bound to every isp_boot_mode_control instance */
`timescale 1ns/1ps
module isp_boot_checker (
  input wire mclk,
  input wire nrst,
  input wire [31:0] wb_adr_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire systemReset,
  input wire pcClear,
  input wire fetchFromLoader,
  input wire extraRamOn,
  input wire ispActive,
  input wire flashOpAllowed
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // a request taken, and a control read answered
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ctl_rd;
    wb_ack_o && $past(wb_adr_i[9:0]) == 10'h2FC && !$past(wb_we_i);
  endsequence
  a_ack_next_cycle: assert property (s_take |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data without ack");
  a_reserved_zero: assert property (s_ctl_rd |->
    wb_dat_o[31:8] == 24'h0 && wb_dat_o[6:5] == 2'h0)
    else $error("reserved bits set");
  a_flash_needs_isp: assert property (flashOpAllowed |-> ispActive)
    else $error("flash op outside isp");
  a_reboot_length: assert property ($rose(systemReset) |->
    systemReset [*4] ##[1:3] !systemReset)
    else $error("reboot pulse length");
  a_reboot_clears: assert property ($fell(systemReset) |->
    !extraRamOn && !ispActive)
    else $error("state kept over reboot");
  a_pc_clear_pulse: assert property (pcClear |=> !pcClear)
    else $error("pc clear held");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |=>
    !wb_ack_o && !systemReset && !ispActive && !extraRamOn)
    else $error("outputs active in reset");
endmodule // isp_boot_checker
bind isp_boot_mode_control isp_boot_checker chk_i (.mclk, .nrst,
  .wb_adr_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .systemReset, .pcClear, .fetchFromLoader, .extraRamOn, .ispActive,
  .flashOpAllowed);

/* File: bench/isp_boot_mode_control_tb_top.sv */
/* self-checking bench for the boot-control block
   assumes the board model and the bound checker */
`timescale 1ns/1ps
module isp_boot_mode_control_tb_top;
  logic mclk = 0, nrst = 0, porEvent = 0, we = 0, cyc = 0, stb = 0;
  logic cpuIdle = 0, cpuWake = 0;
  logic [9:0] adr = 0;
  logic [7:0] dat = 0, q, v;
  logic [1:0] mode = 0;
  wire [31:0] rdat;
  wire ack, sysRst, fromLdr, ram, progLdr, isp, flashOk, sLo, sHi, sOne;
  wire pcClr;
  int miscompares = 0, tests_run = 0, cycles = 0, pcPulses = 0;
  always #2.5 mclk = ~mclk;
  boot_board board (.mode, .bootStrapLow(sLo), .bootStrapHigh(sHi),
    .bootStrapSingle(sOne));
  isp_boot_mode_control uut (.mclk, .nrst, .porEvent,
    .wb_adr_i({22'h0, adr}), .wb_dat_i({24'h0, dat}), .wb_sel_i(4'h1),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cpuIdle, .cpuWake, .bootStrapLow(sLo),
    .bootStrapHigh(sHi), .bootStrapSingle(sOne), .systemReset(sysRst),
    .pcClear(pcClr), .fetchFromLoader(fromLdr), .extraRamOn(ram),
    .reprogramLoaderRom(progLdr), .ispActive(isp),
    .flashOpAllowed(flashOk));
  task conclude;
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // control read image: forced flag on top, bits 6,5,3,2 zero
  function automatic logic [7:0] ctl(input logic f, input logic [7:0] w);
    return {f, 2'b00, w[4], 2'b00, w[1:0]};
  endfunction
  // one classic wishbone cycle, held until ack is sampled
  task bus(input logic [9:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    adr <= a; we <= w; dat <= d; cyc <= 1; stb <= 1;
    do begin @(posedge mclk); n++; end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    cyc <= 0; stb <= 0;
    @(posedge mclk);
  endtask
  task unlock;
    bus(10'h300, 1, 8'h87);
    bus(10'h300, 1, 8'h59);
  endtask
  task rst(input logic [1:0] m);
    mode <= m; nrst <= 0;
    repeat (5) @(posedge mclk);
    nrst <= 1;
    repeat (6) @(posedge mclk);
    mode <= 0;
  endtask
  task idle_wake;
    cpuIdle <= 1;
    repeat (3) @(posedge mclk);
    cpuWake <= 1;
    @(posedge mclk);
    cpuWake <= 0; cpuIdle <= 0;
    repeat (3) @(posedge mclk);
  endtask
  task reboot;
    int n;
    n = 0;
    bus(10'h2FC, 1, 8'h83);
    while (sysRst !== 1'b1 && n < 20) begin @(posedge mclk); n++; end
    while (sysRst !== 1'b0 && n < 40) begin @(posedge mclk); n++; end
    @(posedge mclk);
  endtask
  // count program counter clear pulses as they stand
  always @(posedge mclk) begin
    if (pcClr === 1'b1) pcPulses++;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 5000) begin
      miscompares++;
      conclude;
    end
  end
  initial begin
    v = $urandom(18);
    rst(0);
    chk(fromLdr, 0);
    bus(10'h2FC, 1, 8'h10);
    bus(10'h2FC, 0, 0);
    chk(q, 0);
    unlock;
    repeat (4) begin
      v = $urandom & 8'h72;
      bus(10'h2FC, 1, v);
      bus(10'h2FC, 0, 0);
      chk(q, ctl(0, v));
      chk(ram, v[4]);
      chk(progLdr, !v[1]);
    end
    bus(10'h300, 1, 8'h12);
    bus(10'h2FC, 1, ~v & 8'h12);
    bus(10'h2FC, 0, 0);
    chk(q, ctl(0, v));
    unlock;
    bus(10'h2FC, 1, 8'h00);
    idle_wake;
    chk(isp, 0);
    bus(10'h2FC, 1, 8'h03);
    chk(isp, 0);
    idle_wake;
    chk(isp, 1);
    chk(fromLdr, 1);
    chk(pcPulses[7:0], 8'h01);
    cpuIdle <= 1;
    repeat (3) @(posedge mclk);
    chk(flashOk, 1);
    cpuIdle <= 0;
    repeat (3) @(posedge mclk);
    chk(flashOk, 0);
    reboot;
    bus(10'h2FC, 0, 0);
    chk(q, 0);
    chk(fromLdr, 0);
    for (int m = 1; m < 3; m++) begin
      rst(m[1:0]);
      chk(fromLdr, 1);
      bus(10'h2FC, 0, 0);
      chk(q, 8'h80);
      unlock;
      reboot;
      bus(10'h2FC, 0, 0);
      chk(q, 8'h80);
    end
    porEvent <= 1;
    @(posedge mclk);
    porEvent <= 0;
    repeat (6) @(posedge mclk);
    bus(10'h2FC, 0, 0);
    chk(q, 0);
    conclude;
  end
endmodule // isp_boot_mode_control_tb_top
